// *** pba_arbiter.v ***
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "pba_regs.vh"

// Functional notes
// - Misaligned transfers are accepted only while the misaligned-accept bit is 1.
// - Transfer-error is never driven while error termination is disabled.
// - Address retry is driven only while retry is enabled, and then on every retry condition.
// - Retry covers register write clash, register read during config load, posted write with no buffer and host-bus reads.
// - Prefetched data is kept only when retry and the image's prefetch keep are both enabled.
// - Data parity is checked only while data parity checking is enabled, off after reset.
// - Address parity is checked only while address parity checking is enabled, off after reset.
// - Generated parity is always driven during master writes and slave reads.
// - The parity sense bit selects odd parity at 0 and even parity at 1, for generation and checks.
// - An external master's requests are seen only while its request enable is set.
// - Request enables reset to all zero on host-bus boot and to master 1 only on processor boot.
// - The bridge and each external master have a priority bit, and high priority wins.
// - Requests are sampled one clock after transfer start, or two when the delay bit is set.
// - With no requests the bus parks on the last grantee, or on the selected master when park is set.
// - Park select 0 is the bridge itself and 1 to 3 are external masters 1 to 3.
// - A config master-abort returns all ones when mapped, else transfer-error if enabled.
module pba_arbiter
(
    // APB slave.
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output reg pslverr,
    output wire irq,
    // Boot strap, high for host-bus boot.
    input wire powerup_boot_select,
    // Arbitration.
    input wire transfer_start_n,
    input wire bridge_req,
    input wire [2:0] ext_master_request_n,
    output wire [2:0] ext_master_grant_n,
    output wire bridge_grant,
    // Slave address tenure.
    input wire slv_start,
    input wire slv_misaligned,
    input wire slv_reg_write,
    input wire other_if_reg_write,
    input wire slv_reg_read,
    input wire cfg_load_busy,
    input wire slv_posted_write,
    input wire post_buf_free,
    input wire slv_host_read,
    input wire prefetch_retain_en,
    output reg misalign_accept,
    output reg addr_retry_n,
    output reg bus_error_term_n,
    output wire prefetch_keep,
    // Config cycle master-abort.
    input wire cfg_abort,
    output reg cfg_all_ones,
    // Parity checking.
    input wire addr_valid,
    input wire [31:0] addr_in,
    input wire [3:0] addr_par_in,
    input wire data_valid,
    input wire [31:0] data_in,
    input wire [3:0] data_par_in,
    // Parity generation.
    input wire drive_valid,
    input wire [31:0] drive_data,
    output reg [3:0] par_out,
    output reg par_oe
);

    // ****************************************************************
    // Helpers
    // ****************************************************************

    function [3:0] par_gen;
        input [31:0] d;
        input even;
        integer i;
        begin
            for (i = 0; i < 4; i = i + 1)
                par_gen[i] = ^d[i*8 +: 8] ^ ~even;
        end
    endfunction

    // Round robin pick among req, starting after last.
    function [1:0] rr_pick;
        input [3:0] req;
        input [1:0] last;
        reg [1:0] idx;
        integer k;
        reg found;
        begin
            rr_pick = last;
            found = 1'b0;
            for (k = 1; k < 5; k = k + 1)
            begin
                idx = last + k[1:0];
                if (!found && req[idx])
                begin
                    rr_pick = idx;
                    found = 1'b1;
                end
            end
        end
    endfunction

    // ****************************************************************
    // Registers
    // ****************************************************************

    reg [31:0] misc_q;
    reg [31:0] arb_q;
    reg [`PBA_IRQ_W-1:0] stat_q;
    reg [`PBA_IRQ_W-1:0] mask_q;
    reg [`PBA_IRQ_W-1:0] stat_rd_q;
    reg strap_done_q;
    reg [`PBA_IRQ_W-1:0] ev;

    wire setup = psel & ~penable;
    wire access = psel & penable;
    wire wr = access & pwrite;
    wire hit = (paddr == `PBA_OFS_MISC) | (paddr == `PBA_OFS_ARB) |
        (paddr == `PBA_OFS_IRQ_STAT) | (paddr == `PBA_OFS_IRQ_MASK);

    assign pready = 1'b1;
    assign irq = |(stat_q & mask_q);

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
            stat_rd_q <= {`PBA_IRQ_W{1'b0}};
        end
        else
        begin
            pslverr <= setup & ~hit;
            stat_rd_q <= {`PBA_IRQ_W{1'b0}};
            if (setup)
            begin
                prdata <= 32'h00000000;
                case (paddr)
                    `PBA_OFS_MISC: prdata <= misc_q;
                    `PBA_OFS_ARB: prdata <= arb_q;
                    `PBA_OFS_IRQ_STAT:
                    begin
                        prdata[`PBA_IRQ_W-1:0] <= stat_q;
                        stat_rd_q <= pwrite ? {`PBA_IRQ_W{1'b0}} : stat_q;
                    end
                    `PBA_OFS_IRQ_MASK: prdata[`PBA_IRQ_W-1:0] <= mask_q;
                    default: prdata <= 32'h00000000;
                endcase
            end
        end
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            misc_q <= `PBA_MISC_RESET;
            arb_q <= `PBA_ARB_RESET;
            mask_q <= {`PBA_IRQ_W{1'b0}};
            stat_q <= {`PBA_IRQ_W{1'b0}};
            strap_done_q <= 1'b0;
        end
        else
        begin
            // The strap is caught on the first edge after release.
            strap_done_q <= 1'b1;
            if (!strap_done_q)
                arb_q[`PBA_ARB_REQ_EN] <= powerup_boot_select ?
                    `PBA_EN_BOOT_HOST : `PBA_EN_BOOT_PROC;
            else if (wr && paddr == `PBA_OFS_ARB)
                arb_q <= pwdata & `PBA_ARB_WMASK;
            if (wr && paddr == `PBA_OFS_MISC)
                misc_q <= pwdata & `PBA_MISC_WMASK;
            if (wr && paddr == `PBA_OFS_IRQ_MASK)
                mask_q <= pwdata[`PBA_IRQ_W-1:0];
            // Only bits seen by the read are cleared, and a new event wins.
            if (access && !pwrite && paddr == `PBA_OFS_IRQ_STAT)
                stat_q <= (stat_q & ~stat_rd_q) | ev;
            else
                stat_q <= stat_q | ev;
        end
    end

    wire err_term_en = misc_q[`PBA_MISC_ERR_TERM];
    wire retry_en = misc_q[`PBA_MISC_RETRY_EN];
    wire even = misc_q[`PBA_MISC_PAR_SENSE];

    // ****************************************************************
    // Slave controls
    // ****************************************************************

    wire retry_cond = (slv_reg_write & other_if_reg_write) |
        (slv_reg_read & cfg_load_busy) |
        (slv_posted_write & ~post_buf_free) |
        slv_host_read;
    wire do_retry = slv_start & retry_en & retry_cond;
    wire mis_ok = misc_q[`PBA_MISC_MISALIGN];
    wire mis_rej = slv_start & ~do_retry & slv_misaligned & ~mis_ok;
    wire apar_err = addr_valid & misc_q[`PBA_MISC_APAR_EN] &
        (addr_par_in != par_gen(addr_in, even));
    wire dpar_err = data_valid & misc_q[`PBA_MISC_DPAR_EN] &
        (data_par_in != par_gen(data_in, even));
    wire cfg_map = misc_q[`PBA_MISC_CFG_MAP];

    assign prefetch_keep = retry_en & prefetch_retain_en;

    always @*
    begin
        ev = {`PBA_IRQ_W{1'b0}};
        ev[`PBA_IRQ_APAR] = apar_err;
        ev[`PBA_IRQ_DPAR] = dpar_err;
        ev[`PBA_IRQ_MISALIGN] = mis_rej;
        ev[`PBA_IRQ_CFG_ABORT] = cfg_abort;
        ev[`PBA_IRQ_RETRY] = do_retry;
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            misalign_accept <= 1'b0;
            addr_retry_n <= 1'b1;
            bus_error_term_n <= 1'b1;
            cfg_all_ones <= 1'b0;
            par_out <= 4'h0;
            par_oe <= 1'b0;
        end
        else
        begin
            misalign_accept <= slv_start & ~do_retry & slv_misaligned & mis_ok;
            addr_retry_n <= ~do_retry;
            cfg_all_ones <= cfg_abort & cfg_map;
            // Errors go out on the bus only when enabled; status always, irq only when unmasked.
            bus_error_term_n <= ~(err_term_en &
                (mis_rej | dpar_err | (cfg_abort & ~cfg_map)));
            par_oe <= drive_valid;
            if (drive_valid)
                par_out <= par_gen(drive_data, even);
        end
    end

    // ****************************************************************
    // Arbiter
    // ****************************************************************

    reg ts_d1_q;
    reg ts_d2_q;
    reg busy_q;
    reg [3:0] grant_q;
    reg [1:0] last_q;
    reg [3:0] req;
    reg [3:0] hi;
    reg [1:0] pick;
    wire ts = ~transfer_start_n;
    wire dly = arb_q[`PBA_ARB_REQ_SAMPLE_DELAY];
    wire [3:0] prio = arb_q[`PBA_ARB_PRIO];
    wire sample = dly ? ts_d2_q : ts_d1_q;

    assign bridge_grant = grant_q[0];
    assign ext_master_grant_n = ~grant_q[3:1];

    always @*
    begin
        req = {~ext_master_request_n & arb_q[`PBA_ARB_REQ_EN], bridge_req};
        hi = req & prio;
        if (|hi)
            pick = rr_pick(hi, last_q);
        else
            pick = rr_pick(req, last_q);
        if (~|req)
            pick = arb_q[`PBA_ARB_PARK] ? arb_q[`PBA_ARB_PARK_SEL] : last_q;
    end

    // Between a transfer start and its sample point the grant is frozen.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ts_d1_q <= 1'b0;
            ts_d2_q <= 1'b0;
            busy_q <= 1'b0;
            grant_q <= 4'h1;
            last_q <= 2'h0;
        end
        else
        begin
            ts_d1_q <= ts;
            ts_d2_q <= ts_d1_q;
            if (ts)
                busy_q <= 1'b1;
            else if (sample)
                busy_q <= 1'b0;
            if ((!busy_q && !ts) || sample)
            begin
                grant_q <= 4'h1 << pick;
                if (|req)
                    last_q <= pick;
            end
        end
    end

endmodule

// *** pba_arbiter_bench.sv ***
`timescale 1ns/1ps
`include "pba_regs.vh"
module pba_arbiter_bench;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, powerup_boot_select;
    logic transfer_start_n, bridge_req, bridge_grant, slv_start, prefetch_retain_en;
    logic slv_misaligned, slv_reg_write, other_if_reg_write, slv_reg_read, cfg_load_busy;
    logic slv_posted_write, post_buf_free, slv_host_read, misalign_accept, addr_retry_n;
    logic bus_error_term_n, prefetch_keep, cfg_abort, cfg_all_ones, addr_valid, data_valid;
    logic drive_valid, par_oe, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, addr_in, data_in, drive_data, rd, r;
    logic [3:0] addr_par_in, data_par_in, par_out;
    logic [2:0] ext_master_request_n, ext_master_grant_n, want, seen;
    logic [7:0] q;
    int n_fail, total_checks, i, k;
    assign {slv_misaligned, slv_reg_write, other_if_reg_write, slv_reg_read, cfg_load_busy,
        slv_posted_write, post_buf_free, slv_host_read} = q;
    pba_arbiter u_dut (.*);
    pba_ext_master_model u_far (.*);
    initial
    begin
        pclk = 1'h0;
        forever #5 pclk = ~pclk;
    end
    // ****
    // Shared tasks.
    // ****
    task chk(input [31:0] got, input [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task apb(input logic w, input [11:0] a, input [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task strobe(input [7:0] c, input logic ab);
        @(posedge pclk);
        slv_start <= ~ab;
        cfg_abort <= ab;
        q <= c;
        @(posedge pclk);
        slv_start <= 1'h0;
        cfg_abort <= 1'h0;
        @(negedge pclk);
    endtask
    function [3:0] pgen(input [31:0] d, input s);
        for (int b = 0; b < 4; b++)
            pgen[b] = ^d[8*b +: 8] ^ !s;
    endfunction
    task results;
        $display("checks %0d, mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        #300us;
        n_fail++;
        $display("watchdog expired");
        results;
    end
    // ****
    // Tests.
    // ****
    initial
    begin
        presetn = 1'h0;
        {psel, penable, pwrite, bridge_req, slv_start, prefetch_retain_en, cfg_abort} = '0;
        {addr_valid, data_valid, drive_valid, powerup_boot_select, want} = '0;
        {paddr, pwdata, addr_in, data_in, drive_data, addr_par_in, data_par_in} = '0;
        q = 8'h02;
        r = $urandom(32'hFC0AC617);
        repeat (6) @(posedge pclk);
        presetn <= 1'h1;
        repeat (2) @(posedge pclk);
        apb(1'h0, `PBA_OFS_MISC, 0);
        chk(rd, `PBA_MISC_RESET);
        apb(1'h0, `PBA_OFS_ARB, 0);
        chk(rd, 32'h00020000);
        apb(1'h0, 12'h2D0, 0);
        chk(err, 1);
        r = $urandom;
        apb(1'h1, `PBA_OFS_ARB, r);
        apb(1'h0, `PBA_OFS_ARB, 0);
        chk(rd, r & `PBA_ARB_WMASK);
        $display("registers done");
        for (i = 0; i < 48; i++)
        begin
            r = $urandom;
            apb(1'h1, `PBA_OFS_MISC, 32'h40 | (r & 32'h38));
            prefetch_retain_en <= r[8];
            strobe(r[23:16], 1'h0);
            k = r[3] & ((r[22] & r[21]) | (r[20] & r[19]) | (r[18] & ~r[17]) | r[16]);
            chk(addr_retry_n, !k);
            chk(misalign_accept, !k & r[23] & r[5]);
            chk(bus_error_term_n, !(!k & r[23] & !r[5] & r[4]));
            chk(prefetch_keep, r[3] & r[8]);
        end
        for (i = 0; i < 2; i++)
        begin
            apb(1'h1, `PBA_OFS_MISC, 32'h10 | (i << 6));
            strobe(8'h02, 1'h1);
            chk({cfg_all_ones, bus_error_term_n}, i ? 3 : 0);
        end
        $display("slave controls done");
        apb(1'h0, `PBA_OFS_IRQ_STAT, 0);
        for (i = 0; i < 8; i++)
        begin
            r = $urandom;
            apb(1'h1, `PBA_OFS_MISC, 32'h40 | (i & 3) | ((i & 2) << 1));
            apb(1'h1, `PBA_OFS_IRQ_MASK, i[2]);
            @(posedge pclk);
            {drive_valid, addr_valid, data_valid} <= 3'h7;
            {drive_data, addr_in, data_in} <= {r, r, r};
            addr_par_in <= pgen(r, i[0]) ^ 4'h1;
            data_par_in <= pgen(r, i[0]) ^ 4'h2;
            @(posedge pclk);
            {drive_valid, addr_valid, data_valid} <= 3'h0;
            @(negedge pclk);
            chk({par_oe, par_out}, {1'h1, pgen(r, i[0])});
            chk(irq, i[1] & i[2]);
            apb(1'h0, `PBA_OFS_IRQ_STAT, 0);
            chk(rd, i[1] ? 3 : 0);
            @(negedge pclk);
            chk(irq, 0);
        end
        $display("parity done");
        want <= 3'h7;
        for (i = 0; i < 4; i++)
        begin
            apb(1'h1, `PBA_OFS_ARB, 32'h4 | i);
            repeat (4) @(negedge pclk);
            chk({bridge_grant, ~ext_master_grant_n}, i ? 1 << (i - 1) : 8);
        end
        bridge_req <= 1'h1;
        apb(1'h1, `PBA_OFS_ARB, 32'h000E0400);
        repeat (6) @(negedge pclk);
        chk({bridge_grant, ~ext_master_grant_n}, 2);
        bridge_req <= 1'h0;
        for (k = 0; k < 2; k++)
        begin
            apb(1'h1, `PBA_OFS_ARB, 32'h000E0000 | (k << 3));
            seen = 0;
            repeat (40) @(negedge pclk) seen = seen | ~ext_master_grant_n;
            chk(seen, 7);
        end
        want <= 3'h0;
        $display("arbiter done");
        results;
    end
endmodule
bind pba_arbiter pba_monitor u_mon (.*);

// *** pba_ext_master_model.sv ***
`timescale 1ns/1ps
// ****
// External masters: request while wanted, start a tenure once granted.
// ****
module pba_ext_master_model (
    // Clock and reset.
    input wire pclk,
    input wire presetn,
    // Bench control and bus pins.
    input wire [2:0] want,
    input wire [2:0] ext_master_grant_n,
    output logic [2:0] ext_master_request_n,
    output logic transfer_start_n
);
    // Requests stay up after a start, so the arbiter must rotate by itself.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ext_master_request_n <= 3'h7;
            transfer_start_n <= 1'h1;
        end
        else
        begin
            ext_master_request_n <= ~want;
            transfer_start_n <= ~(|(want & ~ext_master_grant_n) & transfer_start_n);
        end
    end
endmodule

// *** pba_monitor.sv ***
`timescale 1ns/1ps
// ****
// Port checker for the slave controls and the arbiter.
// ****
module pba_monitor (
    // Clock and reset.
    input wire pclk, presetn,
    // Slave side.
    input wire slv_start, slv_misaligned, cfg_abort, cfg_all_ones, data_valid,
    input wire misalign_accept, addr_retry_n, bus_error_term_n, drive_valid, par_oe,
    input wire prefetch_keep, prefetch_retain_en, psel, penable, pslverr,
    // Arbitration.
    input wire bridge_grant,
    input wire [2:0] ext_master_grant_n
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Strobes on the bus pins are single-cycle, so a stuck-low output is caught.
    sequence low_pulse(s);
        !s ##1 s;
    endsequence
    retry_cause_a: assert property ($fell(addr_retry_n) |-> $past(slv_start))
        else $error("retry without a tenure");
    retry_pulse_a: assert property ($fell(addr_retry_n) |-> low_pulse(addr_retry_n))
        else $error("retry not one cycle");
    err_cause_a: assert property ($fell(bus_error_term_n) |->
        $past(slv_start | cfg_abort | data_valid))
        else $error("error strobe without cause");
    err_pulse_a: assert property ($fell(bus_error_term_n) |-> low_pulse(bus_error_term_n))
        else $error("error strobe not one cycle");
    accept_cause_a: assert property (misalign_accept |-> $past(slv_misaligned) && addr_retry_n)
        else $error("accept without misaligned tenure");
    ones_cause_a: assert property (cfg_all_ones |-> $past(cfg_abort))
        else $error("all ones without abort");
    parity_drive_a: assert property (drive_valid |=> par_oe)
        else $error("parity not driven");
    grant_single_a: assert property ($onehot({bridge_grant, ~ext_master_grant_n}))
        else $error("grant not one-hot");
    keep_gate_a: assert property (prefetch_keep |-> prefetch_retain_en)
        else $error("keep without image enable");
    apb_err_a: assert property (pslverr |-> psel && penable)
        else $error("error outside access");
endmodule

// *** pba_regs.vh ***
`ifndef PBA_REGS_VH
`define PBA_REGS_VH

// Register byte addresses.
`define PBA_OFS_MISC 12'h2C0
`define PBA_OFS_ARB 12'h2C4
`define PBA_OFS_IRQ_STAT 12'h2C8
`define PBA_OFS_IRQ_MASK 12'h2CC

// Miscellaneous control fields.
`define PBA_MISC_RETRY_MAX 11:8
`define PBA_MISC_EXT_CYC 7
`define PBA_MISC_CFG_MAP 6
`define PBA_MISC_MISALIGN 5
`define PBA_MISC_ERR_TERM 4
`define PBA_MISC_RETRY_EN 3
`define PBA_MISC_DPAR_EN 2
`define PBA_MISC_APAR_EN 1
`define PBA_MISC_PAR_SENSE 0
`define PBA_MISC_WMASK 32'h00000FFF
`define PBA_MISC_RESET 32'h00000070

// Arbiter control fields.
`define PBA_ARB_REQ_EN 19:17
`define PBA_ARB_PRIO 11:8
`define PBA_ARB_REQ_SAMPLE_DELAY 3
`define PBA_ARB_PARK 2
`define PBA_ARB_PARK_SEL 1:0
`define PBA_ARB_WMASK 32'h000E0F0F
`define PBA_ARB_RESET 32'h00000000
`define PBA_EN_BOOT_PROC 3'h1
`define PBA_EN_BOOT_HOST 3'h0

// Interrupt status bits.
`define PBA_IRQ_W 5
`define PBA_IRQ_APAR 0
`define PBA_IRQ_DPAR 1
`define PBA_IRQ_MISALIGN 2
`define PBA_IRQ_CFG_ABORT 3
`define PBA_IRQ_RETRY 4

`endif
